//--- design/sgp_pkg.sv
package sgp_pkg;
   // ------------------------------------------------------------
   // widths and positions
   // ------------------------------------------------------------
   localparam int PORT_W = 8;
   localparam int PIN_N = 6;
   localparam int PIN_INPUT_ONLY = 3;
   localparam int PIN_TIMER_SHARED = 2;
   localparam int PIN_ZERO = 0;
   localparam int PIN_ONE = 1;
   localparam int CFG_EXTERNAL_MASTER_RESET_PIN_SEL_BIT = 4;
   localparam logic [PIN_N-1:0] DIR_RESET = 6'h3f;
   localparam logic [PIN_N-1:0] LATCH_RESET = 6'h00;
   localparam logic [PIN_N-1:0] WAKE_PINS = 6'h0b;
   localparam logic [PORT_W-PIN_N-1:0] UPPER_ZERO = 2'h0;

   typedef struct packed {
      logic [PIN_N-1:0] latch;
      logic [PIN_N-1:0] dir;
      logic [PIN_N-1:0] pin_last;
      logic [PORT_W-1:0] rdata;
      logic [PIN_N-1:0] drv_n;
      logic [PIN_N-1:0] dout;
      logic [PIN_N-1:0] pull;
      logic wake;
   } sgp_state_t;

   typedef struct packed {
      logic port_wr;
      logic dir_wr;
      logic port_rd;
      logic [PORT_W-1:0] wdata;
   } sgp_cmd_t;
endpackage

//--- design/sgp_port.sv
// Functional notes
// - a port read returns the pin levels, never the latches.
// - the direction register is write-only and resets to all ones.
// - the port is eight bits, six mapped, bits 7 and 6 read zero.
// - pin 3 never drives, whatever its direction bit.
// - a pin given to an alternate function reads zero.
// - pins 0, 1 and 3 share one pull-up and one wake-up control.
// - with master reset on the shared pin, pull-up forced on and wake-up off.
// - the direction register loads only from the working register by its own instruction.
// - direction one means high impedance, zero drives the latch value.
// - the option override of pin 2 beats its direction bit.
// - latches hold until the port register is written again.
// - every bidirectional pin has its own direction bit.
// - configuration bit 4 selects master reset pin function or internal tie-off.
// - a level change on a wake-enabled pin ends sleep.
`timescale 1ns/10ps
`default_nettype none
module sgp_port
   import sgp_pkg::*;
(
   input wire logic ref_clk, // 125 MHz core clock
   input wire logic reset_n, // async, active low
   input wire sgp_pkg::sgp_cmd_t cmd, // core register access
   input wire logic [sgp_pkg::PIN_N-1:0] pin_in, // pin levels
   input wire logic [sgp_pkg::PIN_N-1:0] alt_func, // pin held by alternate function
   input wire logic pullup_en, // common weak pull-up enable
   input wire logic wake_en, // common wake-on-change enable
   input wire logic [sgp_pkg::PORT_W-1:0] config_word, // configuration bits
   input wire logic timer_override, // option reg takes pin 2 driver
   input wire logic sleeping, // core in sleep
   output logic [sgp_pkg::PORT_W-1:0] rdata, // port read data
   output logic [sgp_pkg::PIN_N-1:0] pin_out, // pin output value
   output logic [sgp_pkg::PIN_N-1:0] pin_oe_n, // low while driving
   output logic [sgp_pkg::PIN_N-1:0] pull_en, // weak pull-up per pin
   output logic external_master_reset_pin_enable, // master reset pin active
   output logic wake_pulse // wake from sleep
);
   import sgp_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   sgp_state_t q;
   sgp_state_t next_q;
   logic external_master_reset_pin_sel;
   logic [PIN_N-1:0] wake_mask;
   logic [PIN_N-1:0] hiz;

   // common control of pins 0, 1 and 3 as a per-pin mask
   function automatic logic [PIN_N-1:0] sgp_common_mask(input logic en);
      sgp_common_mask = en ? WAKE_PINS : LATCH_RESET;
   endfunction

   always_comb begin
      external_master_reset_pin_sel = config_word[CFG_EXTERNAL_MASTER_RESET_PIN_SEL_BIT];
      next_q = q;
      if (cmd.port_wr) begin
         next_q.latch = cmd.wdata[PIN_N-1:0];
      end
      if (cmd.dir_wr) begin
         next_q.dir = cmd.wdata[PIN_N-1:0];
      end
      if (cmd.port_rd) begin
         next_q.rdata = {UPPER_ZERO, pin_in & ~alt_func};
      end
      hiz = next_q.dir;
      hiz[PIN_INPUT_ONLY] = 1'b1;
      if (timer_override) begin
         hiz[PIN_TIMER_SHARED] = 1'b1;
      end
      next_q.drv_n = hiz;
      next_q.dout = next_q.latch;
      next_q.pull = sgp_common_mask(pullup_en);
      wake_mask = sgp_common_mask(wake_en);
      if (external_master_reset_pin_sel) begin
         next_q.pull[PIN_INPUT_ONLY] = 1'b1;
         wake_mask[PIN_INPUT_ONLY] = 1'b0;
      end
      next_q.pin_last = pin_in;
      next_q.wake = sleeping && |((pin_in ^ q.pin_last) & wake_mask);
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '{latch: LATCH_RESET, dir: DIR_RESET, pin_last: LATCH_RESET,
                rdata: '0, drv_n: DIR_RESET, dout: LATCH_RESET,
                pull: LATCH_RESET, wake: 1'b0};
         external_master_reset_pin_enable <= 1'b0;
      end else begin
         q <= next_q;
         external_master_reset_pin_enable <= external_master_reset_pin_sel;
      end
   end

   assign rdata = q.rdata;
   assign pin_out = q.dout;
   assign pin_oe_n = q.drv_n;
   assign pull_en = q.pull;
   assign wake_pulse = q.wake;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_upper_zero;
      @(posedge ref_clk) disable iff (!reset_n)
      rdata[PORT_W-1:PIN_N] == UPPER_ZERO;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper bits nonzero");

   property p_read_pins;
      @(posedge ref_clk) disable iff (!reset_n)
      cmd.port_rd |=> rdata[PIN_N-1:0] == ($past(pin_in) & ~$past(alt_func));
   endproperty
   a_read_pins: assert property (p_read_pins) else $error("read not pin level");

   property p_input_only;
      @(posedge ref_clk) disable iff (!reset_n)
      pin_oe_n[PIN_INPUT_ONLY];
   endproperty
   a_input_only: assert property (p_input_only) else $error("pin 3 driven");

   property p_dir_drive;
      @(posedge ref_clk) disable iff (!reset_n)
      cmd.dir_wr && !cmd.wdata[PIN_ZERO] |=> !pin_oe_n[PIN_ZERO];
   endproperty
   a_dir_drive: assert property (p_dir_drive) else $error("pin 0 not driven");

   property p_override;
      @(posedge ref_clk) disable iff (!reset_n)
      timer_override |=> pin_oe_n[PIN_TIMER_SHARED];
   endproperty
   a_override: assert property (p_override) else $error("pin 2 override lost");

   property p_latch_hold;
      @(posedge ref_clk) disable iff (!reset_n)
      !cmd.port_wr |=> $stable(pin_out);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch changed");

   property p_latch_load;
      @(posedge ref_clk) disable iff (!reset_n)
      cmd.port_wr |=> pin_out == $past(cmd.wdata[PIN_N-1:0]);
   endproperty
   a_latch_load: assert property (p_latch_load) else $error("latch not loaded");

   property p_external_master_reset_pin_pull;
      @(posedge ref_clk) disable iff (!reset_n)
      config_word[CFG_EXTERNAL_MASTER_RESET_PIN_SEL_BIT] |=> pull_en[PIN_INPUT_ONLY] && external_master_reset_pin_enable;
   endproperty
   a_external_master_reset_pin_pull: assert property (p_external_master_reset_pin_pull) else $error("external_master_reset_pin pull-up off");

   property p_pull_common;
      @(posedge ref_clk) disable iff (!reset_n)
      pullup_en |=> pull_en[PIN_ZERO] && pull_en[PIN_ONE];
   endproperty
   a_pull_common: assert property (p_pull_common) else $error("pull-up not common");

   property p_wake;
      @(posedge ref_clk) disable iff (!reset_n)
      sleeping && wake_en && (pin_in[PIN_ZERO] != $past(pin_in[PIN_ZERO])) |=> wake_pulse;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake on change");

   // ------------------------------------------------------------
   // direction checks
   // ------------------------------------------------------------
   sequence s_dir_low_zero;
      cmd.dir_wr && !cmd.wdata[PIN_ZERO];
   endsequence

   sequence s_override_twice;
      timer_override ##1 timer_override;
   endsequence

   property p_dir_hold;
      @(posedge ref_clk) disable iff (!reset_n)
      !cmd.dir_wr && $stable(timer_override) |=> $stable(pin_oe_n);
   endproperty
   a_dir_hold: assert property (p_dir_hold) else $error("direction changed");

   property p_dir_release;
      @(posedge ref_clk) disable iff (!reset_n)
      cmd.dir_wr && cmd.wdata[PIN_ONE] |=> pin_oe_n[PIN_ONE];
   endproperty
   a_dir_release: assert property (p_dir_release) else $error("pin 1 not released");

   property p_dir_pin_one;
      @(posedge ref_clk) disable iff (!reset_n)
      cmd.dir_wr && !cmd.wdata[PIN_ONE] |=> !pin_oe_n[PIN_ONE];
   endproperty
   a_dir_pin_one: assert property (p_dir_pin_one) else $error("pin 1 not driven");

   property p_dir_top;
      @(posedge ref_clk) disable iff (!reset_n)
      cmd.dir_wr && !cmd.wdata[PIN_N-1] |=> !pin_oe_n[PIN_N-1];
   endproperty
   a_dir_top: assert property (p_dir_top) else $error("pin 5 not driven");

   property p_dir_top_release;
      @(posedge ref_clk) disable iff (!reset_n)
      cmd.dir_wr && cmd.wdata[PIN_N-1] |=> pin_oe_n[PIN_N-1];
   endproperty
   a_dir_top_release: assert property (p_dir_top_release) else $error("pin 5 not released");

   property p_dir_persist;
      @(posedge ref_clk) disable iff (!reset_n)
      s_dir_low_zero ##1 !cmd.dir_wr |=> !pin_oe_n[PIN_ZERO];
   endproperty
   a_dir_persist: assert property (p_dir_persist) else $error("pin 0 drive lost");

   property p_override_off;
      @(posedge ref_clk) disable iff (!reset_n)
      !timer_override && cmd.dir_wr && !cmd.wdata[PIN_TIMER_SHARED]
      |=> !pin_oe_n[PIN_TIMER_SHARED];
   endproperty
   a_override_off: assert property (p_override_off) else $error("pin 2 not driven");

   property p_override_held;
      @(posedge ref_clk) disable iff (!reset_n)
      s_override_twice |-> pin_oe_n[PIN_TIMER_SHARED];
   endproperty
   a_override_held: assert property (p_override_held) else $error("pin 2 override dropped");

   property p_input_only_dir;
      @(posedge ref_clk) disable iff (!reset_n)
      cmd.dir_wr && !cmd.wdata[PIN_INPUT_ONLY] |=> pin_oe_n[PIN_INPUT_ONLY];
   endproperty
   a_input_only_dir: assert property (p_input_only_dir) else $error("pin 3 enabled");

   // ------------------------------------------------------------
   // read and latch checks
   // ------------------------------------------------------------
   sequence s_port_write_quiet;
      cmd.port_wr ##1 !cmd.port_wr;
   endsequence

   property p_rdata_hold;
      @(posedge ref_clk) disable iff (!reset_n)
      !cmd.port_rd |=> $stable(rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed");

   property p_read_alt;
      @(posedge ref_clk) disable iff (!reset_n)
      cmd.port_rd && alt_func[PIN_ZERO] |=> !rdata[PIN_ZERO];
   endproperty
   a_read_alt: assert property (p_read_alt) else $error("alternate pin read nonzero");

   property p_read_top_alt;
      @(posedge ref_clk) disable iff (!reset_n)
      cmd.port_rd && alt_func[PIN_N-1] |=> !rdata[PIN_N-1];
   endproperty
   a_read_top_alt: assert property (p_read_top_alt) else $error("pin 5 alt read nonzero");

   property p_read_pin_one;
      @(posedge ref_clk) disable iff (!reset_n)
      cmd.port_rd && !alt_func[PIN_ONE] |=> rdata[PIN_ONE] == $past(pin_in[PIN_ONE]);
   endproperty
   a_read_pin_one: assert property (p_read_pin_one) else $error("pin 1 read wrong");

   property p_latch_persist;
      @(posedge ref_clk) disable iff (!reset_n)
      s_port_write_quiet |=> pin_out == $past(cmd.wdata[PIN_N-1:0], 2);
   endproperty
   a_latch_persist: assert property (p_latch_persist) else $error("latch not held");

   // ------------------------------------------------------------
   // pull-up, wake and master reset checks
   // ------------------------------------------------------------
   property p_pull_off;
      @(posedge ref_clk) disable iff (!reset_n)
      !pullup_en && !config_word[CFG_EXTERNAL_MASTER_RESET_PIN_SEL_BIT] |=> pull_en == LATCH_RESET;
   endproperty
   a_pull_off: assert property (p_pull_off) else $error("pull-up stuck on");

   property p_pull_unmapped;
      @(posedge ref_clk) disable iff (!reset_n)
      (pull_en & ~WAKE_PINS) == LATCH_RESET;
   endproperty
   a_pull_unmapped: assert property (p_pull_unmapped) else $error("pull-up on other pin");

   property p_wake_off;
      @(posedge ref_clk) disable iff (!reset_n)
      !wake_en |=> !wake_pulse;
   endproperty
   a_wake_off: assert property (p_wake_off) else $error("wake while disabled");

   property p_wake_awake;
      @(posedge ref_clk) disable iff (!reset_n)
      !sleeping |=> !wake_pulse;
   endproperty
   a_wake_awake: assert property (p_wake_awake) else $error("wake while running");

   property p_external_master_reset_pin_off;
      @(posedge ref_clk) disable iff (!reset_n)
      !config_word[CFG_EXTERNAL_MASTER_RESET_PIN_SEL_BIT] |=> !external_master_reset_pin_enable;
   endproperty
   a_external_master_reset_pin_off: assert property (p_external_master_reset_pin_off) else $error("master reset pin stuck");
endmodule
`default_nettype wire

//--- dv/sgp_pins.sv
`timescale 1ns/10ps
`default_nettype none
module sgp_pins (
   input wire logic clk, // core clock
   input wire logic [5:0] drv, // device value
   input wire logic [5:0] oe_n, // low = device drives
   input wire logic [5:0] ext, // outside level
   output logic [5:0] lvl // pin level
);
   always_ff @(posedge clk) begin
      lvl <= (drv & ~oe_n) | (ext & oe_n);
   end
endmodule
`default_nettype wire

//--- dv/tb_six_pin_gpio_port.sv
`timescale 1ns/10ps
`default_nettype none
module tb_six_pin_gpio_port;
   import sgp_pkg::*;
   logic ref_clk = 0, reset_n = 0, pu = 0, we = 0, tov = 0, slp = 0, mc, wk;
   sgp_cmd_t cmd = '0;
   logic [5:0] alt = 0, ext = 0, lvl, po, poe, pe, e;
   logic [7:0] cfg = 0, rd, w, d;
   int bad_count = 0, num_checks = 0, cyc = 0, ws = 0;
   sgp_port sgp_port_inst (.ref_clk(ref_clk), .reset_n(reset_n), .cmd(cmd), .pin_in(lvl),
      .alt_func(alt), .pullup_en(pu), .wake_en(we), .config_word(cfg), .timer_override(tov),
      .sleeping(slp), .rdata(rd), .pin_out(po), .pin_oe_n(poe), .pull_en(pe),
      .external_master_reset_pin_enable(mc), .wake_pulse(wk));
   sgp_pins sgp_pins_inst (.clk(ref_clk), .drv(po), .oe_n(poe), .ext(ext), .lvl(lvl));
   always #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      ws += (wk === 1'b1);
      if (++cyc > 3000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   task automatic chk(string n, logic [7:0] x, logic [7:0] s);
      num_checks++;
      if (s !== x) begin
         bad_count++;
         $display("ERROR %s exp %h got %h", n, x, s);
      end
   endtask
   task automatic tk(int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic op(logic [2:0] s, logic [7:0] v);
      cmd <= '{s[2], s[1], s[0], v};
      tk(1);
      cmd <= '0;
      tk(3);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   function automatic logic [5:0] oe(logic [5:0] dd, logic t);
      oe = dd | 6'h08 | {3'h0, t, 2'h0};
   endfunction
   initial begin
      void'($urandom(32'hf8e0f4a8));
      tk(20);
      reset_n <= 1;
      tk(1);
      chk("oe", 8'h3f, {2'h0, poe});
      for (int i = 0; i < 30; i++) begin
         w = $urandom;
         d = $urandom;
         alt <= $urandom;
         ext <= $urandom;
         tov <= i[0];
         op(3'b100, w);
         op(3'b010, d);
         op(3'b001, 8'h00);
         e = oe(d[5:0], i[0]);
         chk("out", {2'h0, w[5:0]}, {2'h0, po});
         chk("oe", {2'h0, e}, {2'h0, poe});
         chk("rd", {2'h0, (w[5:0] & ~e | ext & e) & ~alt}, rd);
      end
      alt <= 0;
      pu <= 1;
      tk(3);
      chk("pull", 8'h0b, {2'h0, pe});
      pu <= 0;
      cfg <= 8'h10;
      tk(3);
      chk("pull", 8'h08, {2'h0, pe});
      chk("external_master_reset_pin", 8'h01, {7'h0, mc});
      op(3'b010, 8'h3f);
      ext <= 0;
      we <= 1;
      slp <= 1;
      tk(5);
      ws = 0;
      ext <= 6'h08;
      tk(4);
      chk("wake", 8'h00, 8'(ws));
      cfg <= 0;
      tk(2);
      ext <= 6'h09;
      tk(4);
      chk("wake", 8'h01, 8'(ws));
      tally_and_finish();
   end
endmodule
`default_nettype wire
